// *** ofhp_params.svh ***
`ifndef OFHP_PARAMS_SVH
`define OFHP_PARAMS_SVH
// ****************************************************************
// widths
// ****************************************************************
`define OFHP_ADDR_W 11
`define OFHP_DATA_W 8
`define OFHP_NUM_REGS 2048
// ****************************************************************
// timing
// ****************************************************************
`define OFHP_CLK_NS 100
`define OFHP_RST_MIN_NS 100
`define OFHP_RST_MIN_CYC ((`OFHP_RST_MIN_NS + `OFHP_CLK_NS - 1) / `OFHP_CLK_NS)
// strobe count loaded by the host; rd or wr stays low this many cycles plus one
`define OFHP_STROBE_CYC 4
// ****************************************************************
// interrupt source mapping
// ****************************************************************
`define OFHP_IRQ_W 8
`define OFHP_IRQ_STAT_ADDR 11'h000
`define OFHP_IRQ_MASK_ADDR 11'h001
`define OFHP_IRQ_MASK_RST 8'h00
`endif

// *** ofhp_pkg.sv ***
package ofhp_pkg;
  typedef enum logic [3:0] {
    OFHP_H_IDLE = 4'h1,
    OFHP_H_SEL = 4'h2,
    OFHP_H_STRB = 4'h4,
    OFHP_H_END = 4'h8
  } ofhp_host_state_t;
endpackage

// *** ofhp_if.sv ***
`timescale 1ns/10ps
`include "ofhp_params.svh"
interface ofhp_if;
  logic rst_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic [`OFHP_ADDR_W-1:0] addr;
  logic [`OFHP_DATA_W-1:0] d_host;
  logic d_host_oe;
  logic [`OFHP_DATA_W-1:0] d_dev;
  logic d_dev_oe;
  logic int_oe;
  // shared data bus and open-drain interrupt resolved here
  wire [`OFHP_DATA_W-1:0] d_bus = d_dev_oe ? d_dev : d_host;
  wire int_n = ~int_oe;
  modport dev (
    input rst_n, cs_n, rd_n, wr_n, ale, addr, d_host, d_host_oe,
    output d_dev, d_dev_oe, int_oe
  );
  modport host (
    output rst_n, cs_n, rd_n, wr_n, ale, addr, d_host, d_host_oe,
    input d_dev, d_dev_oe, int_oe
  );
endinterface

// *** ofhp_dev.sv ***
`timescale 1ns/10ps
`include "ofhp_params.svh"
module ofhp_dev (
  // system
  input wire logic clk_i,
  input wire logic rst_n_i,
  // parallel port
  ofhp_if.dev port,
  // interrupt sources, level, acknowledged at origin
  input wire logic [`OFHP_IRQ_W-1:0] irq_src_i,
  // status
  output logic test_mode_o
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [4:0] s1_q, s2_q;
  logic [`OFHP_ADDR_W-1:0] a1_q, a2_q;
  logic [`OFHP_DATA_W-1:0] d1_q, d2_q;
  logic [1:0] fill_q;
  // control pins pass two flops; reset to idle levels so no false edge follows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 5'h1F;
      s2_q <= 5'h1F;
    end else begin
      s1_q <= {port.rst_n, port.cs_n, port.rd_n, port.wr_n, port.ale};
      s2_q <= s1_q;
    end
  end
  // address pins; the host keeps them steady through the whole select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a1_q <= '0;
      a2_q <= '0;
    end else begin
      a1_q <= port.addr;
      a2_q <= a1_q;
    end
  end
  // write data pins; settled before the synchronised write strobe shows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      d1_q <= port.d_host;
      d2_q <= d1_q;
    end
  end
  // the second flops hold reset values until two real samples have passed;
  // until then a high chip select says nothing about the pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_q <= 2'h0;
    end else begin
      fill_q <= {fill_q[0], 1'b1};
    end
  end
  wire live = fill_q[1];
  wire prst_n = s2_q[4];
  wire cs_n = s2_q[3];
  wire rd_n = s2_q[2];
  wire wr_n = s2_q[1];
  wire ale = s2_q[0];
  // ****************************************************************
  // access tracking
  // ****************************************************************
  logic cs_q, ale_q, armed_q, done_q, test_q, mux_q;
  logic [`OFHP_ADDR_W-1:0] lat_q;
  wire cs_fall = ~cs_n & cs_q;
  wire sel = ~cs_n;
  // one write per chip select fall; a second write strobe is ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b1;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else if (!prst_n) begin
      cs_q <= 1'b1;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cs_q <= cs_n;
      if (cs_fall) begin
        armed_q <= 1'b1;
        done_q <= 1'b0;
      end else if (cs_n) begin
        armed_q <= 1'b0;
      end
      if (sel && armed_q && wr_n == 1'b0)
        done_q <= 1'b1;
    end
  end
  // test modes leave on the first high chip select really seen on the pin;
  // the idle reset value of the synchroniser does not count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_q <= 1'b1;
    end else if (live && cs_n) begin
      test_q <= 1'b0;
    end
  end
  assign test_mode_o = test_q;
  // previous latch enable level, reset high to match its pulled-up idle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_q <= 1'b1;
    end else begin
      ale_q <= ale;
    end
  end
  // address latch on falling latch enable; held until it rises again
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_q <= '0;
      mux_q <= 1'b0;
    end else if (ale_q && !ale) begin
      lat_q <= a2_q;
      mux_q <= 1'b1;
    end else if (ale) begin
      mux_q <= 1'b0;
    end
  end
  wire [`OFHP_ADDR_W-1:0] addr = mux_q ? lat_q : a2_q;
  // ****************************************************************
  // register store
  // ****************************************************************
  logic [`OFHP_DATA_W-1:0] mem_q [`OFHP_NUM_REGS];
  logic [`OFHP_IRQ_W-1:0] pend_q, mask_q;
  // an access counts only once selected, armed by a fresh select and out of reset
  wire acc_ok = sel && armed_q && prst_n;
  // one write per select, and none while test modes still hold the port
  wire wr_go = acc_ok && !done_q && !wr_n && !test_q;
  // ordinary registers are plain storage
  always_ff @(posedge clk_i) begin
    if (wr_go)
      mem_q[addr] <= d2_q;
  end
  // pending sources are levels held at their origin, so a copy is enough
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= irq_src_i;
    end
  end
  // mask register; a port reset returns it to its reset value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= `OFHP_IRQ_MASK_RST;
    end else if (!prst_n) begin
      mask_q <= `OFHP_IRQ_MASK_RST;
    end else if (wr_go && addr == `OFHP_IRQ_MASK_ADDR) begin
      mask_q <= d2_q;
    end
  end
  // ****************************************************************
  // read path and interrupt
  // ****************************************************************
  logic [`OFHP_DATA_W-1:0] rdat_q;
  logic oe_q, int_q;
  // drive bus only in a selected read; no fight with host writes
  // limitation: the bus is let go three cycles after the strobe rises, so the
  // host must not start a write before then
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= acc_ok && !rd_n && wr_n;
    end
  end
  // read data follows the address every cycle, so it has settled long
  // before the host samples it at the end of its strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdat_q <= '0;
    end else if (addr == `OFHP_IRQ_STAT_ADDR) begin
      rdat_q <= pend_q;
    end else if (addr == `OFHP_IRQ_MASK_ADDR) begin
      rdat_q <= mask_q;
    end else begin
      rdat_q <= mem_q[addr];
    end
  end
  // open drain: enable pulls low while unmasked source pends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_q <= 1'b0;
    end else begin
      int_q <= |(pend_q & mask_q);
    end
  end
  assign port.d_dev = rdat_q;
  assign port.d_dev_oe = oe_q;
  assign port.int_oe = int_q;
endmodule

// *** ofhp_host.sv ***
`timescale 1ns/10ps
`include "ofhp_params.svh"
module ofhp_host (
  // system
  input wire logic clk_i,
  input wire logic rst_n_i,
  // user request
  input wire logic req_i,
  input wire logic req_wr_i,
  input wire logic [`OFHP_ADDR_W-1:0] req_addr_i,
  input wire logic [`OFHP_DATA_W-1:0] req_wdata_i,
  input wire logic dev_rst_i,
  // user answer
  output logic busy_o,
  output logic done_o,
  output logic [`OFHP_DATA_W-1:0] rdata_o,
  output logic irq_o,
  // parallel port
  ofhp_if.host port
);
  localparam int RC = (`OFHP_RST_MIN_CYC < 1) ? 1 : `OFHP_RST_MIN_CYC;
  ofhp_pkg::ofhp_host_state_t st_q;
  logic [3:0] cnt_q;
  logic cs_q, rd_q, wr_q, oe_q, wrk_q, done_q, rstn_q, busy_q;
  logic [`OFHP_ADDR_W-1:0] a_q;
  logic [`OFHP_DATA_W-1:0] wd_q, rd_d_q;
  logic i1_q, i2_q, irq_q;
  logic [3:0] rc_q;
  // hold device reset low for the minimum width
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_q <= 4'(RC);
      rstn_q <= 1'b0;
    end else if (dev_rst_i) begin
      rc_q <= 4'(RC);
      rstn_q <= 1'b0;
    end else if (rc_q != 4'h0) begin
      rc_q <= rc_q - 4'h1;
    end else begin
      rstn_q <= 1'b1;
    end
  end
  // access sequencer; chip select idles high, clearing test modes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ofhp_pkg::OFHP_H_IDLE;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      oe_q <= 1'b0;
      cnt_q <= 4'h0;
      wrk_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      a_q <= '0;
      wd_q <= '0;
      rd_d_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ofhp_pkg::OFHP_H_IDLE: begin
          if (req_i && rstn_q) begin
            a_q <= req_addr_i;
            wd_q <= req_wdata_i;
            wrk_q <= req_wr_i;
            oe_q <= req_wr_i;
            cs_q <= 1'b0;
            busy_q <= 1'b1;
            st_q <= ofhp_pkg::OFHP_H_SEL;
          end
        end
        ofhp_pkg::OFHP_H_SEL: begin
          rd_q <= wrk_q;
          wr_q <= ~wrk_q;
          cnt_q <= 4'(`OFHP_STROBE_CYC);
          st_q <= ofhp_pkg::OFHP_H_STRB;
        end
        ofhp_pkg::OFHP_H_STRB: begin
          // device answers after its two-flop sync, so wait the strobe out
          if (cnt_q == 4'h0) begin
            if (!wrk_q)
              rd_d_q <= port.d_dev;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            st_q <= ofhp_pkg::OFHP_H_END;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ofhp_pkg::OFHP_H_END: begin
          cs_q <= 1'b1;
          busy_q <= 1'b0;
          oe_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= ofhp_pkg::OFHP_H_IDLE;
        end
        default: st_q <= ofhp_pkg::OFHP_H_IDLE;
      endcase
    end
  end
  // interrupt pin is asynchronous to us
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i1_q <= 1'b0;
      i2_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      i1_q <= port.int_oe;
      i2_q <= i1_q;
      irq_q <= i2_q;
    end
  end
  assign port.rst_n = rstn_q;
  assign port.cs_n = cs_q;
  assign port.rd_n = rd_q;
  assign port.wr_n = wr_q;
  assign port.ale = 1'b1;
  assign port.addr = a_q;
  assign port.d_host = wd_q;
  assign port.d_host_oe = oe_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rdata_o = rd_d_q;
  assign irq_o = irq_q;
endmodule

// *** ofhp_chk.sv ***
`timescale 1ns/10ps
// ****************************************************************
// port protocol checker
// ****************************************************************
module ofhp_chk (
  // system
  input wire logic clk_i,
  input wire logic rst_n_i,
  // port wires
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic d_host_oe,
  input wire logic d_dev_oe,
  input wire logic int_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // strobes are five cycles low, then lift
  sequence s_rd_pulse;
    !rd_n [*5] ##1 rd_n;
  endsequence
  sequence s_wr_pulse;
    !wr_n [*5] ##1 wr_n;
  endsequence
  a_rd_width:
    assert property ($fell(rd_n) |-> s_rd_pulse) else $error("read strobe width wrong");
  a_wr_width:
    assert property ($fell(wr_n) |-> s_wr_pulse) else $error("write strobe width wrong");
  // a strobe must follow a fresh select fall by one cycle
  a_fresh_select:
    assert property (($fell(rd_n) || $fell(wr_n)) |-> $past(cs_n, 2) && !$past(cs_n))
      else $error("strobe without fresh select");
  a_select_holds:
    assert property ((!rd_n || !wr_n) |-> !cs_n) else $error("select lifted mid access");
  a_select_release:
    assert property (($rose(rd_n) || $rose(wr_n)) |=> $rose(cs_n))
      else $error("select not lifted after strobe");
  a_read_drives:
    assert property ($fell(rd_n) && !cs_n |-> ##[2:3] d_dev_oe) else $error("read data not driven");
  // allow for the strobe synchroniser before the device lets go
  a_quiet_unsel:
    assert property (cs_n [*4] |-> !d_dev_oe) else $error("device drives while unselected");
  a_no_fight:
    assert property (!(d_dev_oe && d_host_oe)) else $error("both ends drive data");
  a_latch_high:
    assert property (ale) else $error("latch enable low on separate bus");
  a_reset_int:
    assert property ($fell(rst_n) |-> ##[1:6] !int_oe) else $error("interrupt kept through reset");
endmodule

// *** octal_framer_host_port_bench.sv ***
`timescale 1ns/10ps
`include "ofhp_params.svh"
module octal_framer_host_port_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic req_wr = 1'b0;
  logic [`OFHP_ADDR_W-1:0] req_addr = '0;
  logic [`OFHP_DATA_W-1:0] req_wdata = '0;
  logic dev_rst = 1'b0;
  logic [`OFHP_IRQ_W-1:0] irq_src = '0;
  logic busy, done, irq, test_mode;
  logic [`OFHP_DATA_W-1:0] rdata, r;
  int error_cnt = 0;
  int checks_done = 0;
  // ****************************************************************
  // clock, ends and checker
  // ****************************************************************
  always #50 clk = ~clk;
  ofhp_if i_ofhp_if();
  ofhp_dev i_ofhp_dev(.clk_i(clk), .rst_n_i(rst_n), .port(i_ofhp_if.dev),
    .irq_src_i(irq_src), .test_mode_o(test_mode));
  ofhp_host i_ofhp_host(.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .req_wr_i(req_wr),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .dev_rst_i(dev_rst), .busy_o(busy),
    .done_o(done), .rdata_o(rdata), .irq_o(irq), .port(i_ofhp_if.host));
  ofhp_chk i_ofhp_chk(.clk_i(clk), .rst_n_i(rst_n), .rst_n(i_ofhp_if.rst_n),
    .cs_n(i_ofhp_if.cs_n), .rd_n(i_ofhp_if.rd_n), .wr_n(i_ofhp_if.wr_n),
    .ale(i_ofhp_if.ale), .d_host_oe(i_ofhp_if.d_host_oe),
    .d_dev_oe(i_ofhp_if.d_dev_oe), .int_oe(i_ofhp_if.int_oe));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one access; done is polled with a bound so a dead host cannot hang us
  task access(input logic wr, input logic [10:0] a, input logic [7:0] wd);
    int n;
    @(negedge clk);
    req = 1'b1;
    req_wr = wr;
    req_addr = a;
    req_wdata = wd;
    @(negedge clk);
    req = 1'b0;
    check("busy", busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("done", done, 1'b1);
    check("busy_end", busy, 1'b0);
    r = rdata;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_storage;
    logic [10:0] at [3];
    at = '{11'h7FF, 11'h3A5, 11'h002};
    check("test_mode", test_mode, 1'b0);
    for (int i = 0; i < 3; i++) access(1'b1, at[i], ~at[i][7:0]);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, at[i], 8'h00);
      check("storage", r, 8'(~at[i][7:0]));
    end
  endtask
  task t_irq;
    irq_src = 8'h04;
    repeat (8) @(negedge clk);
    check("irq_masked", irq, 1'b0);
    access(1'b1, 11'h001, 8'h04);
    repeat (8) @(negedge clk);
    check("irq_on", irq, 1'b1);
    check("int_pin", i_ofhp_if.int_n, 1'b0);
    access(1'b0, 11'h000, 8'h00);
    check("status", r, 8'h04);
    // acknowledge at origin, leave a masked source pending
    irq_src = 8'h02;
    repeat (8) @(negedge clk);
    check("irq_off", irq, 1'b0);
  endtask
  task t_dev_reset;
    irq_src = 8'h04;
    repeat (8) @(negedge clk);
    check("irq_before", irq, 1'b1);
    dev_rst = 1'b1;
    @(negedge clk);
    dev_rst = 1'b0;
    repeat (10) @(negedge clk);
    check("irq_reset", irq, 1'b0);
    access(1'b0, 11'h001, 8'h00);
    check("mask_reset", r, 8'h00);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("test_mode_on", test_mode, 1'b1);
    repeat (2) @(negedge clk);
    t_storage();
    t_irq();
    t_dev_reset();
    stop_test();
  end
  // watchdog, far beyond the roughly 130 cycles the run needs
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule
